// File: src/alarm_pkg.sv
// package: register map, field layout and reset values of the alarm unit
// assumes: a 32-bit avalon-mm slave, word addressed by byte offset
package alarm_pkg;
   // =================================================
   // register byte offsets
   localparam logic [3:0] OFS_UPPER_CFG = 4'h0;   // upper alarm configuration
   localparam logic [3:0] OFS_LOWER_CFG = 4'h4;   // lower alarm configuration
   localparam logic [3:0] OFS_STATUS    = 4'h8;   // sticky status, w1c
   localparam logic [3:0] OFS_MASK      = 4'hC;   // interrupt mask
   localparam int          ADDR_W        = 4;      // byte address width
   // =================================================
   // configuration field layout
   localparam int CFG_W      = 16;                 // config register width
   localparam int THR_W      = 12;                 // threshold width
   localparam int THR_LSB    = 0;                  // threshold low bit
   localparam int TRIP_LSB   = 12;                 // trip count low bit
   localparam int TRIP_W     = 3;                  // trip count width
   localparam int MODE_BIT   = 15;                 // consecutive mode bit
   localparam int CNT_W      = 4;                  // trip counter width
   // =================================================
   // reset values
   localparam logic [15:0] UPPER_CFG_RST = 16'h0FFF;  // threshold all ones
   localparam logic [15:0] LOWER_CFG_RST = 16'h0000;  // threshold zero
   // =================================================
   // status and mask bits
   localparam int ST_W     = 2;                    // status width
   localparam int ST_UPPER = 0;                    // upper_alarm_flag
   localparam int ST_LOWER = 1;                    // lower_alarm_flag
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000; // unmapped read
endpackage

// File: src/trip_counter.sv
// trip_counter: one alarm's comparator, trip counter and flag set pulse
// assumes: results and controls all on sys_clk, restart has priority
`timescale 1ns/1ps
`default_nettype none
module trip_counter
   import alarm_pkg::*;
#(
   parameter bit IS_UPPER = 1'b1                    // 1 above, 0 below
)(
   input  wire logic                sys_clk,
   input  wire logic                rstn,
   input  wire logic [THR_W-1:0]    result,         // conversion result
   input  wire logic                result_valid,   // one-cycle result strobe
   input  wire logic                bipolar,        // two's complement mode
   input  wire logic [CFG_W-1:0]    cfg,            // configuration word
   input  wire logic                restart,        // clear trip counter
   output logic                     trip_hit        // pulse, count reached
);
   // =================================================
   // compare and count
   logic [CNT_W-1:0] count_ff;                      // trips so far
   logic [THR_W-1:0] thr;                           // threshold field
   logic [CNT_W-1:0] need;                          // required trips
   logic             exceed;                        // strict comparison met

   // flip msb so signed values compare as unsigned
   function automatic logic [THR_W-1:0] bias(input logic [THR_W-1:0] v,
                                             input logic bp);
      bias = bp ? {~v[THR_W-1], v[THR_W-2:0]} : v;
   endfunction

   assign thr = cfg[THR_LSB +: THR_W];
   assign need = {1'b0, cfg[TRIP_LSB +: TRIP_W]} + 4'h1;
   // strict, sign aware comparison
   assign exceed = IS_UPPER ?
      (bias(result, bipolar) > bias(thr, bipolar)) :
      (bias(result, bipolar) < bias(thr, bipolar));

   // counter: restart wins, then count, miss in consecutive mode clears
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count_ff <= 4'h0;
         trip_hit <= 1'b0;
      end else if (restart) begin
         count_ff <= 4'h0;
         trip_hit <= 1'b0;
      end else if (result_valid) begin
         if (exceed) begin
            // reaching the target raises the flag and starts again
            if (count_ff + 4'h1 >= need) begin
               count_ff <= 4'h0;
               trip_hit <= 1'b1;
            end else begin
               count_ff <= count_ff + 4'h1;
               trip_hit <= 1'b0;
            end
         end else begin
            // consecutive mode loses progress on a miss
            if (cfg[MODE_BIT]) begin
               count_ff <= 4'h0;
            end
            trip_hit <= 1'b0;
         end
      end else begin
         trip_hit <= 1'b0;
      end
   end

   a_miss_clears: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && !restart && !exceed && cfg[MODE_BIT]
      |=> count_ff == 4'h0)
      else $error("consecutive miss did not clear count");
   a_restart_zero: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      restart |=> count_ff == 4'h0 && !trip_hit)
      else $error("restart did not clear count");
   a_hit_cause: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      trip_hit |-> $past(result_valid) && $past(exceed))
      else $error("hit without exceeding result");
endmodule
`default_nettype wire

// File: src/alarm_unit.sv
// alarm_unit: two threshold alarms with avalon-mm registers and interrupt
// assumes: results arrive on sys_clk as one-cycle strobes; bipolar is static
`timescale 1ns/1ps
`default_nettype none
module alarm_unit
   import alarm_pkg::*;
(
   input  wire logic                       sys_clk,
   input  wire logic                       rstn,
   input  wire logic [alarm_pkg::ADDR_W-1:0] avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic [31:0]                     avs_readdata,
   output logic                            avs_waitrequest,
   input  wire logic [alarm_pkg::THR_W-1:0] result,
   input  wire logic                       result_valid,
   input  wire logic                       bipolar,
   output logic                            irq
);
   // =================================================
   // bus handshake
   // every access takes two cycles: wait high, then one answer cycle
   logic             ack_ff;                          // answer cycle marker
   logic             acc;                             // access completes now
   logic [CFG_W-1:0] upper_alarm_config_ff;           // upper config
   logic [CFG_W-1:0] lower_alarm_config_ff;           // lower config
   logic [ST_W-1:0]  status_ff;                       // sticky flags
   logic [ST_W-1:0]  mask_ff;                         // interrupt mask
   logic             wr_upper;                        // upper config write
   logic             wr_lower;                        // lower config write
   logic             rd_status;                       // status read
   logic [ST_W-1:0]  w1c;                             // bits cleared by write
   logic             hit_upper;                       // upper count reached
   logic             hit_lower;                       // lower count reached
   logic             restart_upper;                   // upper count restart
   logic             restart_lower;                   // lower count restart
   logic [ST_W-1:0]  rd_clear;                        // flags a read reported
   logic             clr_upper;                       // upper flag clear
   logic             clr_lower;                       // lower flag clear

   // merge byte lanes of a 16-bit write into an old value
   function automatic logic [15:0] lane16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] be);
      lane16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   assign acc = (avs_read || avs_write) && ack_ff;

   // waitrequest falls for one cycle per access
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= (avs_read || avs_write) && !ack_ff;
      end
   end

   // waitrequest high unless answering
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_ff);
      end
   end

   // =================================================
   // decode
   assign wr_upper  = acc && avs_write && avs_address == OFS_UPPER_CFG;
   assign wr_lower  = acc && avs_write && avs_address == OFS_LOWER_CFG;
   assign rd_status = acc && avs_read && avs_address == OFS_STATUS;
   // a read drops only the flags it reported; a flag set while the
   // read waited stays up for the next read instead of being lost
   assign rd_clear  = rd_status ? avs_readdata[ST_W-1:0] : 2'b00;
   assign w1c = (acc && avs_write && avs_address == OFS_STATUS
                 && avs_byteenable[0]) ? avs_writedata[ST_W-1:0] : 2'b00;
   // every cause that drops a flag
   assign clr_upper = rd_clear[ST_UPPER] || wr_upper || w1c[ST_UPPER];
   assign clr_lower = rd_clear[ST_LOWER] || wr_lower || w1c[ST_LOWER];

   // configuration registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         upper_alarm_config_ff <= UPPER_CFG_RST;
         lower_alarm_config_ff <= LOWER_CFG_RST;
      end else begin
         if (wr_upper) begin
            upper_alarm_config_ff <= lane16(upper_alarm_config_ff,
                                            avs_writedata, avs_byteenable);
         end
         if (wr_lower) begin
            lower_alarm_config_ff <= lane16(lower_alarm_config_ff,
                                            avs_writedata, avs_byteenable);
         end
      end
   end

   // mask register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mask_ff <= 2'b00;
      end else if (acc && avs_write && avs_address == OFS_MASK
                   && avs_byteenable[0]) begin
         mask_ff <= avs_writedata[ST_W-1:0];
      end
   end

   // read data, registered at the end of the wait cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= UNMAPPED_DATA;
      end else if (avs_read && !ack_ff) begin
         case (avs_address)
            OFS_UPPER_CFG: avs_readdata <= {16'h0000, upper_alarm_config_ff};
            OFS_LOWER_CFG: avs_readdata <= {16'h0000, lower_alarm_config_ff};
            OFS_STATUS:    avs_readdata <= {30'h0, status_ff};
            OFS_MASK:      avs_readdata <= {30'h0, mask_ff};
            default:       avs_readdata <= UNMAPPED_DATA;
         endcase
      end
   end

   // =================================================
   // alarms
   // a flag cleared by read or config write restarts the count
   assign restart_upper = wr_upper || rd_clear[ST_UPPER];
   assign restart_lower = wr_lower || rd_clear[ST_LOWER];

   trip_counter #(.IS_UPPER(1'b1)) u_upper (
      .sys_clk      (sys_clk),
      .rstn         (rstn),
      .result       (result),
      .result_valid (result_valid),
      .bipolar      (bipolar),
      .cfg          (upper_alarm_config_ff),
      .restart      (restart_upper),
      .trip_hit     (hit_upper)
   );

   trip_counter #(.IS_UPPER(1'b0)) u_lower (
      .sys_clk      (sys_clk),
      .rstn         (rstn),
      .result       (result),
      .result_valid (result_valid),
      .bipolar      (bipolar),
      .cfg          (lower_alarm_config_ff),
      .restart      (restart_lower),
      .trip_hit     (hit_lower)
   );

   // sticky status: set wins over clear by read, config write or w1c
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         status_ff <= 2'b00;
      end else begin
         if (hit_upper) begin
            status_ff[ST_UPPER] <= 1'b1;
         end else if (clr_upper) begin
            status_ff[ST_UPPER] <= 1'b0;
         end
         if (hit_lower) begin
            status_ff[ST_LOWER] <= 1'b1;
         end else if (clr_lower) begin
            status_ff[ST_LOWER] <= 1'b0;
         end
      end
   end

   // interrupt level
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_ff & mask_ff);
      end
   end

   // =================================================
   // checks
   // flags: a hit always lands in the status register
   a_upper_flag_set: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      hit_upper |=> status_ff[ST_UPPER])
      else $error("upper flag not set");

   a_lower_flag_set: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      hit_lower |=> status_ff[ST_LOWER])
      else $error("lower flag not set");

   // flags: only a hit or a clear moves them
   a_upper_sticky: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !hit_upper && !clr_upper |=> $stable(status_ff[ST_UPPER]))
      else $error("upper flag moved by itself");

   a_lower_sticky: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !hit_lower && !clr_lower |=> $stable(status_ff[ST_LOWER]))
      else $error("lower flag moved by itself");

   // clears: config write drops the flag unless a hit lands
   a_upper_cfg_clear: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      wr_upper && !hit_upper |=> !status_ff[ST_UPPER])
      else $error("upper config write kept flag");

   a_lower_cfg_clear: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      wr_lower && !hit_lower |=> !status_ff[ST_LOWER])
      else $error("lower config write kept flag");

   // clears: a status read drops what it reported
   a_read_clear: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      rd_status && !hit_upper && !hit_lower
      |=> (status_ff & $past(rd_clear)) == 2'b00)
      else $error("status read did not clear");

   // clears: writing a one drops the flag
   a_w1c_clear: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      acc && avs_write && avs_address == OFS_STATUS
      && avs_byteenable[0] && avs_writedata[ST_UPPER] && !hit_upper
      |=> !status_ff[ST_UPPER])
      else $error("write one kept upper flag");

   // restart: a read or config write clear never lets a hit through
   a_upper_restart: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      restart_upper |=> !hit_upper)
      else $error("upper hit across restart");

   a_lower_restart: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      restart_lower |=> !hit_lower)
      else $error("lower hit across restart");

   // counting: code zero trips on a single result
   a_single_trip: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && !restart_upper
      && upper_alarm_config_ff[TRIP_LSB +: TRIP_W] == 3'h0 && !bipolar
      && result > upper_alarm_config_ff[THR_W-1:0] |=> hit_upper)
      else $error("code zero needs one trip");

   a_lower_single_trip: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && !restart_lower && !bipolar
      && lower_alarm_config_ff[TRIP_LSB +: TRIP_W] == 3'h0
      && result < lower_alarm_config_ff[THR_W-1:0] |=> hit_lower)
      else $error("lower code zero needs one trip");

   // counting: bipolar compares as two's complement
   a_upper_signed: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && bipolar && !restart_upper
      && upper_alarm_config_ff[TRIP_LSB +: TRIP_W] == 3'h0
      && $signed(result) > $signed(upper_alarm_config_ff[THR_W-1:0])
      |=> hit_upper)
      else $error("signed upper result missed");

   a_lower_signed: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && bipolar && !restart_lower
      && lower_alarm_config_ff[TRIP_LSB +: TRIP_W] == 3'h0
      && $signed(result) < $signed(lower_alarm_config_ff[THR_W-1:0])
      |=> hit_lower)
      else $error("signed lower result missed");

   // counting: equal or wrong-side results never trip
   a_equal_no_trip: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && result == lower_alarm_config_ff[THR_W-1:0]
      |=> !hit_lower)
      else $error("equal result counted");

   a_upper_no_hit: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && !bipolar
      && result <= upper_alarm_config_ff[THR_W-1:0] |=> !hit_upper)
      else $error("upper hit without higher result");

   a_lower_no_hit: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      result_valid && !bipolar
      && result >= lower_alarm_config_ff[THR_W-1:0] |=> !hit_lower)
      else $error("lower hit without lower result");

   a_hit_needs_result: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !result_valid |=> !hit_upper && !hit_lower)
      else $error("hit without a result");

   // bus: exactly one answer cycle per access
   a_wait_answer: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      (avs_read || avs_write) && !ack_ff |=> !avs_waitrequest)
      else $error("access not answered");

   a_wait_single: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");

   a_mask_write: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      acc && avs_write && avs_address == OFS_MASK && avs_byteenable[0]
      |=> mask_ff == $past(avs_writedata[ST_W-1:0]))
      else $error("mask write lost");

   // interrupt follows unmasked flags
   a_irq_level: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      |(status_ff & mask_ff) |=> irq)
      else $error("irq not raised");

   a_irq_clear: assert property (
      @(posedge sys_clk) disable iff (!rstn)
      !(|(status_ff & mask_ff)) |=> !irq)
      else $error("irq without unmasked flag");

   // main scenarios
   c_upper_hit: cover property (@(posedge sys_clk) disable iff (!rstn)
      hit_upper);
   c_lower_hit: cover property (@(posedge sys_clk) disable iff (!rstn)
      hit_lower);
   c_read_clear: cover property (@(posedge sys_clk) disable iff (!rstn)
      rd_status && |status_ff);
   c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) irq);
   c_bipolar_trip: cover property (@(posedge sys_clk) disable iff (!rstn)
      bipolar && (hit_upper || hit_lower));
endmodule
`default_nettype wire

// File: bench/result_source.sv
// result_source: converter model feeding results to the alarm unit
// assumes: bench calls its tasks; one result per clock at most
`timescale 1ns/1ps
`default_nettype none
module result_source
   import alarm_pkg::*;
(
   input  wire logic              sys_clk,
   output logic [alarm_pkg::THR_W-1:0] result,
   output logic                   result_valid
);
   // =================================================
   // result strobe
   initial begin
      result       = '0;
      result_valid = 1'b0;
   end
   // one result; strobe stays up when called back to back
   task automatic send(input logic [THR_W-1:0] v);
      @(posedge sys_clk);
      result       <= v;
      result_valid <= 1'b1;
   endtask
   // drop strobe, scramble idle bus, wait n cycles
   task automatic pause(input int n);
      @(posedge sys_clk);
      result_valid <= 1'b0;
      result       <= ~result;
      repeat (n) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// tb_top: self-checking bench for the alarm unit
// assumes: alarm_pkg, alarm_unit and result_source compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import alarm_pkg::*;
   // =================================================
   // signals
   logic              sys_clk;     // 20 mhz clock
   logic              rstn;        // async reset, low
   logic [ADDR_W-1:0] avs_address; // byte offset
   logic              avs_read;    // read strobe
   logic              avs_write;   // write strobe
   logic [31:0]       avs_wdata;   // write data
   logic [3:0]        avs_be;      // byte lanes
   logic [31:0]       avs_rdata;   // read data
   logic              avs_wait;    // slave stall
   logic [THR_W-1:0]  result;      // converter result
   logic              res_vld;     // result strobe
   logic              bipolar;     // compare format
   logic              irq;         // interrupt line
   logic [31:0]       rd;          // last read data
   logic [ADDR_W-1:0] a;           // scenario offset
   logic [THR_W-1:0]  v;           // scenario hit value
   int                n_mismatch;  // mismatches
   int                num_checks;  // comparisons
   // =================================================
   // clock, design, converter model
   always #25 sys_clk = ~sys_clk;
   alarm_unit dut_u (.sys_clk(sys_clk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_wdata),
      .avs_byteenable(avs_be), .avs_readdata(avs_rdata),
      .avs_waitrequest(avs_wait), .result(result),
      .result_valid(res_vld), .bipolar(bipolar), .irq(irq));
   result_source src_u (.sys_clk(sys_clk), .result(result),
      .result_valid(res_vld));
   // =================================================
   // tasks
   task automatic check(input string w, input logic [31:0] s,
                        input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", w, e, s);
      end
   endtask
   // one access, held until waitrequest sampled low
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] ad,
                      input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= ad;
      avs_wdata   <= d;
      avs_write   <= wr;
      avs_read    <= ~wr;
      @(posedge sys_clk);
      // only the watchdog ends a wait
      while (avs_wait !== 1'b0) @(posedge sys_clk);
      rd = avs_rdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] ad, input logic [31:0] e);
      bus(1'b0, ad, 32'h0000_0000);
      check("register", rd, e);
   endtask
   task automatic stat(input logic [1:0] e);
      rdchk(OFS_STATUS, {30'h0000_0000, e});
   endtask
   function automatic logic [31:0] cfg(input logic m, input logic [2:0] c,
                                       input logic [11:0] t);
      return {16'h0000, m, c, t};
   endfunction
   // consecutive mode: a miss (equal value) restarts the count
   task automatic consec(input logic [ADDR_W-1:0] ad,
                         input logic [11:0] hit, input logic [1:0] e);
      bus(1'b1, ad, cfg(1'b1, 3'h2, 12'h100));
      src_u.send(hit);
      src_u.send(hit);
      src_u.send(12'h100);
      src_u.send(hit);
      src_u.send(hit);
      src_u.pause(3);
      stat(2'h0);
      src_u.send(hit);
      src_u.pause(3);
      stat(e);
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // =================================================
   // watchdog
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      end_sim;
   end
   // =================================================
   // main sequence
   initial begin
      sys_clk     = 1'b0;
      rstn        = 1'b0;
      avs_address = '0;
      avs_read    = 1'b0;
      avs_write   = 1'b0;
      avs_wdata   = '0;
      avs_be      = 4'hF;
      bipolar     = 1'b0;
      n_mismatch  = 0;
      num_checks  = 0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      check("irq", {31'h0, irq}, 32'h0);
      rdchk(OFS_UPPER_CFG, {16'h0000, UPPER_CFG_RST});
      rdchk(OFS_LOWER_CFG, 32'h0000_0000);
      rdchk(OFS_MASK, 32'h0000_0000);
      bus(1'b1, 4'h1, 32'hFFFF_FFFF);
      rdchk(4'h1, UNMAPPED_DATA);
      // reset thresholds disable both; equal never trips
      src_u.send(12'hFFF);
      src_u.send(12'h000);
      src_u.pause(3);
      stat(2'h0);
      // byte lanes: each lane of a config write lands alone
      avs_be <= 4'h1;
      bus(1'b1, OFS_UPPER_CFG, 32'hFFFF_FF34);
      rdchk(OFS_UPPER_CFG, 32'h0000_0F34);
      avs_be <= 4'h2;
      bus(1'b1, OFS_UPPER_CFG, 32'h0000_8000);
      rdchk(OFS_UPPER_CFG, 32'h0000_8034);
      avs_be <= 4'hF;
      // every trip code, cumulative mode so interleaved misses do not reset
      for (int k = 0; k < 8; k++) begin
         bus(1'b1, OFS_UPPER_CFG, cfg(1'b0, 3'(k), 12'h100));
         bus(1'b1, OFS_LOWER_CFG, cfg(1'b0, 3'(k), 12'h100));
         for (int i = 0; i < k; i++) begin
            src_u.send(12'h200);
            src_u.send(12'h050);
         end
         src_u.pause(3);
         stat(2'h0);
         src_u.send(12'h101);
         src_u.send(12'h0FF);
         src_u.pause(3);
         stat(2'h3);
         stat(2'h0);
      end
      consec(OFS_UPPER_CFG, 12'h200, 2'h1);
      consec(OFS_LOWER_CFG, 12'h0FF, 2'h2);
      // config write clears a partial count
      for (int s = 0; s < 2; s++) begin
         a = s ? OFS_LOWER_CFG : OFS_UPPER_CFG;
         v = s ? 12'h0FF : 12'h200;
         bus(1'b1, a, cfg(1'b0, 3'h1, 12'h100));
         src_u.send(v);
         src_u.pause(1);
         bus(1'b1, a, cfg(1'b0, 3'h1, 12'h100));
         src_u.send(v);
         src_u.pause(3);
         stat(2'h0);
         src_u.send(v);
         src_u.pause(3);
         stat(s ? 2'h2 : 2'h1);
      end
      // interrupt: masked, unmasked, cleared by write-one
      bus(1'b1, OFS_MASK, 32'h0000_0001);
      src_u.send(12'h050);
      src_u.send(12'h050);
      src_u.pause(4);
      check("irq", {31'h0, irq}, 32'h0);
      bus(1'b1, OFS_MASK, 32'h0000_0003);
      repeat (2) @(posedge sys_clk);
      check("irq", {31'h0, irq}, 32'h1);
      bus(1'b1, OFS_STATUS, 32'h0000_0002);
      repeat (2) @(posedge sys_clk);
      check("irq", {31'h0, irq}, 32'h0);
      stat(2'h0);
      rdchk(OFS_MASK, 32'h0000_0003);
      // bipolar compare: -1 is below zero
      bipolar <= 1'b1;
      bus(1'b1, OFS_UPPER_CFG, cfg(1'b0, 3'h0, 12'h000));
      bus(1'b1, OFS_LOWER_CFG, cfg(1'b0, 3'h0, 12'h000));
      src_u.send(12'hFFF);
      src_u.pause(3);
      stat(2'h2);
      src_u.send(12'h001);
      src_u.pause(3);
      stat(2'h1);
      bus(1'b1, OFS_UPPER_CFG, cfg(1'b0, 3'h0, 12'h7FF));
      bus(1'b1, OFS_LOWER_CFG, cfg(1'b0, 3'h0, 12'h800));
      src_u.send(12'h7FF);
      src_u.send(12'h800);
      src_u.pause(3);
      stat(2'h0);
      end_sim;
   end
endmodule
`default_nettype wire
